// ---- design/aio_cfg.svh ----
// bit positions, reset values and codes for the analog i/o host interface
`ifndef AIO_CFG_SVH
`define AIO_CFG_SVH

// bit-serial block: 16 bit positions, base picked by switches
`define AIO_SIO_IDX_W 4
`define AIO_SIO_CHAN_BITS 4'h6
`define AIO_SIO_IDX_START 4'h8
`define AIO_SIO_IDX_MEM_EN 4'hc
`define AIO_SIO_IDX_TRIG_EN 4'hd
`define AIO_SIO_IDX_BUSY 4'he
`define AIO_SIO_IDX_VALID 4'hf
`define AIO_SIO_RESULT_BITS 4'hc

// result coding switch settings
`define AIO_CODE_STRAIGHT 2'h0
`define AIO_CODE_OFFSET 2'h1
`define AIO_CODE_TWOS 2'h2

// reset values
`define AIO_RST_MEM_EN 1'b0
`define AIO_RST_TRIG_EN 1'b0
`define AIO_RST_CHAN 6'h00
`define AIO_RST_RESULT 16'h0000
`define AIO_RST_DAC 12'h000

`endif

// ---- design/aio_dac_chan.sv ----
// one output converter latch, keeps the low bits of the written word
`timescale 1ns/1ps
`include "aio_cfg.svh"
module aio_dac_chan #(
    parameter int DATA_W = 16,
    parameter int CONV_W = 12
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic wr_in,
    input wire logic [DATA_W-1:0] data_in,
    output logic [CONV_W-1:0] dac_out
);
    typedef struct packed {
        logic [CONV_W-1:0] value;
    } aio_dac_st_t;

    aio_dac_st_t s;
    aio_dac_st_t next_s;

    generate
        if (CONV_W < 1 || CONV_W > DATA_W) begin : g_bad_width
            $error("aio_dac_chan needs 1 <= CONV_W <= DATA_W");
        end
    endgenerate

    // upper bits of the word are dropped, value is right-justified
    always_comb begin
        next_s = s;
        if (wr_in) begin
            next_s.value = data_in[CONV_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s.value <= CONV_W'(`AIO_RST_DAC);
        end else begin
            s <= next_s;
        end
    end

    assign dac_out = s.value;
endmodule

// ---- design/aio_host_if.sv ----
// host-side digital interface of the analog input and analog output boards
`timescale 1ns/1ps
`include "aio_cfg.svh"
// Contract
// - conversions start by bit-serial command, by a stalled memory read, or by the external trigger.
// - power-up or bus i/o reset leaves command mode only, memory mode and trigger both off.
// - bit-serial bit 12 written one enables memory-mapped conversion, written zero disables it.
// - bit-serial bit 13 written one enables the external trigger, written zero disables it.
// - the board owns 16 bit positions of the bit-serial space at a switch-set base.
// - memory mode decodes 64 consecutive word addresses at a switch-set base, one per input channel.
// - a read of a decoded channel starts its conversion and pulls READY low at once.
// - at conversion end READY is released and the result is driven onto the data bus.
// - channel select serves 64 single-ended or 32 differential inputs.
// - result coding is fixed by switches, not by software.
// - the output board decodes four addresses and a write latches the word into that converter.
// - the converter value sits right-justified and the top four bits of the word are ignored.
// - the output board answers writes only and never drives the data bus on reads.
// - a jumper spaces the four output addresses either consecutively or 16 words apart.
// - the coding is straight binary, offset binary or two's complement.
module aio_host_if
    import aio_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic bus_io_reset_n_in,
    input wire logic [11:0] sio_addr_in,
    input wire logic sio_wr_in,
    input wire logic sio_wdata_in,
    output logic sio_rdata_out,
    input wire logic [7:0] sio_base_sw_in,
    input wire logic [15:0] mem_addr_in,
    input wire logic mem_rd_in,
    input wire logic mem_wr_in,
    input wire logic [15:0] mem_data_in,
    output logic [15:0] mem_data_out,
    output logic mem_data_oe_out,
    output logic ready_out,
    output logic ready_oe_out,
    input wire logic [8:0] mem_base_sw_in,
    input wire logic diff_sw_in,
    input wire logic [1:0] code_sw_in,
    input wire logic [12:0] dac_base_sw_in,
    input wire logic dac_spread_in,
    input wire logic ext_trig_in,
    output logic adc_start_out,
    output logic [5:0] adc_chan_out,
    output logic adc_diff_out,
    output logic conv_busy_out,
    input wire logic adc_done_in,
    input wire logic [11:0] adc_data_in,
    output logic [3:0][11:0] dac_value_out
);
    aio_state_t s;
    aio_state_t next_s;
    aio_ctl_t ctl_raw;
    aio_ctl_t c;
    aio_pins_t pins_raw;
    aio_pins_t p;

    logic io_rst;
    logic sio_hit;
    logic [3:0] sio_idx;
    logic sio_wr_hit;
    logic mem_hit;
    logic rd_req;
    logic [5:0] mem_chan;
    logic dac_hit;
    logic [1:0] dac_sel;
    logic wr_rise;
    logic trig_rise;
    logic done_rise;
    logic sio_start;

    // every pin passes two flops before any logic looks at it
    assign ctl_raw = '{io_rst_n: bus_io_reset_n_in, mem_rd: mem_rd_in, mem_wr: mem_wr_in,
                       sio_wr: sio_wr_in, sio_wdata: sio_wdata_in, ext_trig: ext_trig_in,
                       adc_done: adc_done_in};
    assign pins_raw = '{mem_addr: mem_addr_in, mem_data: mem_data_in, sio_addr: sio_addr_in,
                        adc_data: adc_data_in, sio_base: sio_base_sw_in, mem_base: mem_base_sw_in,
                        dac_base: dac_base_sw_in, diff: diff_sw_in, code: code_sw_in,
                        spread: dac_spread_in};

    aio_sync #(.WIDTH($bits(aio_ctl_t))) u_sync_ctl (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .async_in(ctl_raw),
        .sync_out(c)
    );

    // addresses settle with the strobes, edges are taken in that same cycle
    aio_sync #(.WIDTH($bits(aio_pins_t))) u_sync_pins (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .async_in(pins_raw),
        .sync_out(p)
    );

    // result coding from the switches only
    function automatic logic [15:0] code_result(input logic [1:0] code, input logic [11:0] raw);
        logic sgn;
        sgn = ~raw[11];
        case (code)
            `AIO_CODE_TWOS: code_result = {{4{sgn}}, sgn, raw[10:0]};
            `AIO_CODE_OFFSET: code_result = {4'h0, raw};
            default: code_result = {4'h0, raw};
        endcase
    endfunction

    // address decode for both boards and edge detection
    always_comb begin
        io_rst = ~c.io_rst_n;
        sio_hit = (p.sio_addr[11:4] == p.sio_base);
        sio_idx = p.sio_addr[3:0];
        sio_wr_hit = c.sio_wr & ~s.prev.sio_wr & sio_hit;
        sio_start = sio_wr_hit & (sio_idx == `AIO_SIO_IDX_START) & c.sio_wdata;
        mem_hit = (p.mem_addr[15:7] == p.mem_base);
        mem_chan = p.mem_addr[6:1];
        if (p.diff) begin
            mem_chan[5] = 1'b0;
        end
        rd_req = c.mem_rd & mem_hit & s.mem_en;
        if (p.spread) begin
            dac_hit = (p.mem_addr[15:7] == p.dac_base[12:4]) && (p.mem_addr[4:0] == 5'h00);
            dac_sel = p.mem_addr[6:5];
        end else begin
            dac_hit = (p.mem_addr[15:3] == p.dac_base) && !p.mem_addr[0];
            dac_sel = p.mem_addr[2:1];
        end
        wr_rise = c.mem_wr & ~s.prev.mem_wr;
        trig_rise = c.ext_trig & ~s.prev.ext_trig;
        done_rise = c.adc_done & ~s.prev.adc_done;
    end

    // sequencer, mode bits, read-back and output latch strobes
    always_comb begin
        next_s = s;
        next_s.prev = c;
        next_s.adc_start = 1'b0;
        next_s.dac_wr = 4'h0;
        next_s.ready_lvl = 1'b0;
        next_s.diff = p.diff;
        if (sio_wr_hit) begin
            if (sio_idx < `AIO_SIO_CHAN_BITS) begin
                next_s.cmd_chan[sio_idx[2:0]] = c.sio_wdata;
            end
            if (sio_idx == `AIO_SIO_IDX_MEM_EN) begin
                next_s.mem_en = c.sio_wdata;
            end
            if (sio_idx == `AIO_SIO_IDX_TRIG_EN) begin
                next_s.trig_en = c.sio_wdata;
            end
        end
        // bus reset wins over a write in the same cycle
        if (io_rst) begin
            next_s.mem_en = `AIO_RST_MEM_EN;
            next_s.trig_en = `AIO_RST_TRIG_EN;
        end
        case (s.fsm)
            AIO_IDLE: begin
                // memory read first: the cpu is already stalled on it
                if (rd_req) begin
                    next_s.fsm = AIO_CONV;
                    next_s.adc_start = 1'b1;
                    next_s.conv_chan = mem_chan;
                    next_s.from_mem = 1'b1;
                end else if (sio_start || (s.trig_en && trig_rise)) begin
                    next_s.fsm = AIO_CONV;
                    next_s.adc_start = 1'b1;
                    next_s.conv_chan = {s.cmd_chan[5] & ~p.diff, s.cmd_chan[4:0]};
                    next_s.from_mem = 1'b0;
                    next_s.valid = 1'b0;
                end
            end
            AIO_CONV: begin
                // new starts and triggers are simply not looked at here
                if (done_rise) begin
                    next_s.result = code_result(p.code, p.adc_data);
                    if (s.from_mem) begin
                        next_s.fsm = AIO_HOLD;
                        next_s.data_oe = 1'b1;
                    end else begin
                        next_s.fsm = AIO_IDLE;
                        next_s.valid = 1'b1;
                    end
                end
            end
            AIO_HOLD: begin
                // data stays on the bus until the cpu ends its read
                if (!c.mem_rd) begin
                    next_s.fsm = AIO_IDLE;
                    next_s.data_oe = 1'b0;
                end
            end
            default: begin
                next_s.fsm = AIO_IDLE;
                next_s.data_oe = 1'b0;
            end
        endcase
        // a pending read also stalls while a command conversion finishes
        next_s.ready_oe = (rd_req && next_s.fsm != AIO_HOLD) ||
                          (next_s.fsm == AIO_CONV && next_s.from_mem);
        next_s.busy = (next_s.fsm != AIO_IDLE); // busy comes from its own flop
        // output board: write strobes only, nothing on reads
        if (wr_rise && dac_hit) begin
            next_s.dac_wr[dac_sel] = 1'b1;
            next_s.dac_data = p.mem_data;
        end
        // bit-serial read-back of one position of the block
        next_s.sio_rdata = 1'b0;
        if (sio_hit) begin
            if (sio_idx < `AIO_SIO_RESULT_BITS) begin
                next_s.sio_rdata = s.result[sio_idx];
            end else if (sio_idx == `AIO_SIO_IDX_MEM_EN) begin
                next_s.sio_rdata = s.mem_en;
            end else if (sio_idx == `AIO_SIO_IDX_TRIG_EN) begin
                next_s.sio_rdata = s.trig_en;
            end else if (sio_idx == `AIO_SIO_IDX_BUSY) begin
                next_s.sio_rdata = (s.fsm != AIO_IDLE);
            end else begin
                next_s.sio_rdata = s.valid;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s <= '0;
            s.fsm <= AIO_IDLE;
            s.mem_en <= `AIO_RST_MEM_EN;
            s.trig_en <= `AIO_RST_TRIG_EN;
            s.cmd_chan <= `AIO_RST_CHAN;
            s.conv_chan <= `AIO_RST_CHAN;
            s.result <= `AIO_RST_RESULT;
            s.prev <= '0;
        end else begin
            s <= next_s;
        end
    end

    // four output latches, one per channel
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_dac
            aio_dac_chan #(.DATA_W(16), .CONV_W(12)) u_dac (
                .sys_clk_in(sys_clk_in),
                .nrst_in(nrst_in),
                .wr_in(s.dac_wr[gi]),
                .data_in(s.dac_data),
                .dac_out(dac_value_out[gi])
            );
        end
    endgenerate

    // all outputs straight from flops
    assign sio_rdata_out = s.sio_rdata;
    assign mem_data_out = s.result;
    assign mem_data_oe_out = s.data_oe;
    assign ready_out = s.ready_lvl;
    assign ready_oe_out = s.ready_oe;
    assign adc_start_out = s.adc_start;
    assign adc_chan_out = s.conv_chan;
    assign adc_diff_out = s.diff;
    assign conv_busy_out = s.busy;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!nrst_in);

    chk_mem_stall: assert property (
        (s.fsm == AIO_IDLE && rd_req) |=> (ready_oe_out && adc_start_out && conv_busy_out))
        else $error("memory read did not stall and start a conversion");
    chk_ready_release: assert property (
        (s.fsm == AIO_CONV && s.from_mem && done_rise) |=> (!ready_oe_out && mem_data_oe_out)
            ##1 (mem_data_oe_out || !$past(c.mem_rd)))
        else $error("ready not released with data on the bus");
    chk_bus_io_reset_n_mode: assert property (
        io_rst |=> (!s.mem_en && !s.trig_en))
        else $error("bus reset left a conversion mode enabled");
    chk_mem_en_write: assert property (
        (sio_wr_hit && sio_idx == `AIO_SIO_IDX_MEM_EN && !io_rst) |=> (s.mem_en == $past(c.sio_wdata)))
        else $error("memory mode bit not written");
    chk_trig_en_write: assert property (
        (sio_wr_hit && sio_idx == `AIO_SIO_IDX_TRIG_EN && !io_rst) |=> (s.trig_en == $past(c.sio_wdata)))
        else $error("trigger enable bit not written");
    chk_trig_ignored: assert property (
        (s.fsm == AIO_CONV && trig_rise) |=> !adc_start_out)
        else $error("trigger during conversion started another one");
    chk_trig_start: assert property (
        (s.fsm == AIO_IDLE && s.trig_en && trig_rise && !rd_req) |=> (adc_start_out && !s.from_mem))
        else $error("enabled trigger did not start a conversion");
    chk_drive_only_hold: assert property (
        mem_data_oe_out |-> (s.fsm == AIO_HOLD && s.from_mem))
        else $error("data bus driven outside a stalled channel read");
    chk_dac_latch: assert property (
        s.dac_wr[0] |=> (dac_value_out[0] == $past(s.dac_data[11:0])))
        else $error("output channel 0 did not latch the low bits");
    chk_diff_chan: assert property (
        (adc_start_out && adc_diff_out) |-> !adc_chan_out[5])
        else $error("differential mode selected a channel above 31");

    cov_mem_conv: cover property (rd_req ##1 ready_oe_out ##[1:1000] mem_data_oe_out);
    cov_trig_conv: cover property (s.trig_en && trig_rise && s.fsm == AIO_IDLE);
    cov_cmd_conv: cover property (sio_start && s.fsm == AIO_IDLE);
    cov_dac_write: cover property (wr_rise && dac_hit && p.spread);
endmodule

// ---- design/aio_pkg.sv ----
// types shared by the analog i/o host interface
package aio_pkg;

    // conversion sequencer states
    typedef enum logic [1:0] {
        AIO_IDLE = 2'b00,
        AIO_CONV = 2'b01,
        AIO_HOLD = 2'b10
    } aio_fsm_t;

    // strobes and levels from the bus and the converter
    typedef struct packed {
        logic io_rst_n;
        logic mem_rd;
        logic mem_wr;
        logic sio_wr;
        logic sio_wdata;
        logic ext_trig;
        logic adc_done;
    } aio_ctl_t;

    // address, data and switch pins
    typedef struct packed {
        logic [15:0] mem_addr;
        logic [15:0] mem_data;
        logic [11:0] sio_addr;
        logic [11:0] adc_data;
        logic [7:0] sio_base;
        logic [8:0] mem_base;
        logic [12:0] dac_base;
        logic diff;
        logic [1:0] code;
        logic spread;
    } aio_pins_t;

    // all state of the top module
    typedef struct packed {
        aio_fsm_t fsm;
        logic mem_en;
        logic trig_en;
        logic [5:0] cmd_chan;
        logic [5:0] conv_chan;
        logic from_mem;
        logic [15:0] result;
        logic valid;
        aio_ctl_t prev;
        logic adc_start;
        logic diff;
        logic ready_oe;
        logic ready_lvl;
        logic data_oe;
        logic sio_rdata;
        logic [3:0] dac_wr;
        logic [15:0] dac_data;
        logic busy;
    } aio_state_t;

endpackage

// ---- design/aio_sync.sv ----
// two-flop synchroniser for a vector of pins
`timescale 1ns/1ps
module aio_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } aio_sync_st_t;

    aio_sync_st_t s;
    aio_sync_st_t next_s;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("aio_sync needs WIDTH of at least 1");
        end
    endgenerate

    // meta stage feeds only the stable stage
    always_comb begin
        next_s.meta = async_in;
        next_s.stable = s.meta;
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sync_out = s.stable;
endmodule

// ---- testbench/aio_adc_model.sv ----
// converter model: answers each start pulse with done and a result after a delay
`timescale 1ns/1ps
module aio_adc_model (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic start_in,
    input wire logic slow_in,
    input wire logic [11:0] value_in,
    output logic done_out,
    output logic [11:0] data_out
);
    int cnt;
    // data settles one cycle before done rises and stays while done is high;
    // afterwards the data lines are inverted so a stale sample cannot pass
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt <= 0;
            done_out <= 1'b0;
            data_out <= 12'h000;
        end else if (start_in) begin
            cnt <= slow_in ? 40 : 8; // slow mode keeps the cpu stalled longer
            done_out <= 1'b0;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
            if (cnt == 6)
                data_out <= value_in;
            if (cnt == 5)
                done_out <= 1'b1;
            if (cnt == 1) begin
                done_out <= 1'b0;
                data_out <= ~value_in;
            end
        end
    end
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench for the analog i/o host interface
`timescale 1ns/1ps
`include "aio_cfg.svh"
module testbench
    import aio_pkg::*;
;
    logic sys_clk_in, nrst_in, io_rst_n, sio_wr, sio_wd, mem_rd, mem_wr, diff_sw, spread, trig, slow;
    logic [11:0] sio_addr, adc_val, adc_data;
    logic [7:0] sio_base;
    logic [15:0] mem_addr, mem_wdata, mem_rdata, rnd;
    logic [8:0] mem_base;
    logic [12:0] dac_base;
    logic [1:0] code;
    logic sio_rd, data_oe, ready, ready_oe, adc_start, adc_diff, busy, adc_done, b;
    logic [5:0] adc_chan, last_ch;
    logic [3:0][11:0] dac_val, dac_exp;
    int errors, n_compared, cycles, starts, s0, i, k;

    aio_host_if u_aio_host_if (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .bus_io_reset_n_in(io_rst_n),
        .sio_addr_in(sio_addr), .sio_wr_in(sio_wr), .sio_wdata_in(sio_wd), .sio_rdata_out(sio_rd),
        .sio_base_sw_in(sio_base), .mem_addr_in(mem_addr), .mem_rd_in(mem_rd), .mem_wr_in(mem_wr),
        .mem_data_in(mem_wdata), .mem_data_out(mem_rdata), .mem_data_oe_out(data_oe), .ready_out(ready),
        .ready_oe_out(ready_oe), .mem_base_sw_in(mem_base), .diff_sw_in(diff_sw), .code_sw_in(code),
        .dac_base_sw_in(dac_base), .dac_spread_in(spread), .ext_trig_in(trig), .adc_start_out(adc_start),
        .adc_chan_out(adc_chan), .adc_diff_out(adc_diff), .conv_busy_out(busy), .adc_done_in(adc_done),
        .adc_data_in(adc_data), .dac_value_out(dac_val));
    aio_adc_model u_aio_adc_model (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .start_in(adc_start),
        .slow_in(slow), .value_in(adc_val), .done_out(adc_done), .data_out(adc_data));

    // free-running clock, 5 ns period
    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end

    // hang guard and start-pulse counter, sampled where outputs have settled
    always @(negedge sys_clk_in) begin
        cycles++;
        if (nrst_in && adc_start === 1'b1)
            starts++;
        if (cycles == 40000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [15:0] lfsr(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // reference coding: two's complement flips the msb and sign-extends
    function automatic logic [15:0] coded(logic [11:0] raw, logic [1:0] c);
        logic [11:0] v;
        v = (c == 2'h2) ? raw ^ 12'h800 : raw;
        return (c == 2'h2) ? {{4{v[11]}}, v} : {4'h0, v};
    endfunction

    function automatic logic [15:0] chan_exp(logic [5:0] ch);
        return {10'h0, diff_sw ? {1'b0, ch[4:0]} : ch};
    endfunction

    task automatic tick(int n);
        repeat (n) @(negedge sys_clk_in);
    endtask

    // bounded wait on one of the design's status outputs
    function automatic logic pick(int w);
        return (w == 0) ? busy : data_oe;
    endfunction
    task automatic wait_on(int w, logic v, int lim);
        for (int j = 0; j < lim && pick(w) !== v; j++)
            tick(1);
        check("wait", {15'h0, pick(w)}, {15'h0, v});
    endtask

    // strobes stay high and low three cycles each, as the synchronisers need
    task automatic sio_write(logic [3:0] idx, logic v, logic [7:0] base);
        sio_addr = {base, idx};
        sio_wd = v;
        sio_wr = 1'b1;
        tick(3);
        sio_wr = 1'b0;
        tick(3);
    endtask
    task automatic sio_read(logic [3:0] idx, output logic v);
        sio_addr = {sio_base, idx};
        tick(5);
        v = sio_rd;
    endtask

    task automatic cmd_conv(logic [5:0] ch);
        logic [15:0] got;
        for (int j = 0; j < 6; j++)
            sio_write(j[3:0], ch[j], sio_base);
        last_ch = ch;
        adc_val = rnd[11:0];
        rnd = lfsr(rnd);
        s0 = starts;
        sio_write(`AIO_SIO_IDX_START, 1'b1, sio_base);
        wait_on(0, 1'b0, 200);
        check("starts", 16'(starts), 16'(s0 + 1));
        check("adc_chan", {10'h0, adc_chan}, chan_exp(ch));
        check("adc_diff", {15'h0, adc_diff}, {15'h0, diff_sw});
        for (int j = 0; j < 12; j++) begin
            sio_read(j[3:0], got[j]);
        end
        check("sio result", {4'h0, got[11:0]}, coded(adc_val, code) & 16'h0fff);
        sio_read(`AIO_SIO_IDX_VALID, b);
        check("valid", {15'h0, b}, 16'h1);
    endtask

    // stalled read: hold the strobe until the board drives data
    task automatic mem_read(logic [15:0] a, logic hit, logic [15:0] ch);
        adc_val = rnd[11:0];
        slow = rnd[1];
        rnd = lfsr(rnd);
        mem_addr = a;
        mem_rd = 1'b1;
        tick(4);
        check("ready_oe", {15'h0, ready_oe}, {15'h0, hit});
        if (hit) begin
            check("ready", {15'h0, ready}, 16'h0);
            check("mem chan", {10'h0, adc_chan}, ch);
            wait_on(1, 1'b1, 200);
            check("ready off", {15'h0, ready_oe}, 16'h0);
            check("mem data", mem_rdata, coded(adc_val, code));
        end else begin
            check("data_oe", {15'h0, data_oe}, 16'h0);
        end
        mem_rd = 1'b0;
        wait_on(1, 1'b0, 10);
        slow = 1'b0;
    endtask

    task automatic dac_write(logic [15:0] a, logic [15:0] d);
        mem_addr = a;
        mem_wdata = d;
        mem_wr = 1'b1;
        tick(3);
        mem_wr = 1'b0;
        tick(3);
    endtask

    task automatic trig_pulse();
        trig = 1'b1;
        tick(3);
        trig = 1'b0;
        tick(3);
    endtask

    // main sequence
    initial begin
        {nrst_in, io_rst_n, sio_wr, sio_wd, mem_rd, mem_wr, diff_sw, spread, trig, slow} = '0;
        {sio_addr, adc_val, mem_addr, mem_wdata, code} = '0;
        sio_base = 8'h12;
        mem_base = 9'h1c0;
        dac_base = 13'h1f00;
        dac_exp = '0;
        rnd = 16'd26428;
        tick(4);
        nrst_in = 1'b1;
        io_rst_n = 1'b1;
        tick(4);
        check("reset outs", {busy, ready_oe, data_oe, adc_start, 12'h0}, 16'h0);
        check("reset dac", {15'h0, |dac_val}, 16'h0);
        sio_read(`AIO_SIO_IDX_MEM_EN, b);
        check("mem_en rst", {15'h0, b}, 16'h0);
        // every coding switch setting, differential channels on the odd settings only
        for (k = 0; k < 4; k++) begin
            code = k[1:0];
            diff_sw = k[0];
            cmd_conv(rnd[5:0] | 6'h20);
            rnd = lfsr(rnd);
        end
        // memory-mapped conversions
        sio_write(`AIO_SIO_IDX_MEM_EN, 1'b1, sio_base ^ 8'h01);
        sio_read(`AIO_SIO_IDX_MEM_EN, b);
        check("foreign base", {15'h0, b}, 16'h0);
        sio_write(`AIO_SIO_IDX_MEM_EN, 1'b1, sio_base);
        sio_read(`AIO_SIO_IDX_MEM_EN, b);
        check("mem_en", {15'h0, b}, 16'h1);
        for (k = 0; k < 4; k++) begin
            diff_sw = k[0];
            code = k[1:0];
            mem_read({mem_base, rnd[5:0], 1'b0}, 1'b1, chan_exp(rnd[5:0]));
            rnd = lfsr(rnd);
        end
        mem_read({mem_base, 6'h3f, 1'b0}, 1'b1, chan_exp(6'h3f));
        mem_read({mem_base + 9'h1, 7'h0}, 1'b0, 16'h0);
        mem_read({dac_base, 3'h0}, 1'b0, 16'h0);
        sio_write(`AIO_SIO_IDX_MEM_EN, 1'b0, sio_base);
        mem_read({mem_base, 7'h02}, 1'b0, 16'h0);
        // trigger: one start per edge, edges during a conversion dropped
        sio_write(`AIO_SIO_IDX_TRIG_EN, 1'b1, sio_base);
        sio_read(`AIO_SIO_IDX_TRIG_EN, b);
        check("trig_en", {15'h0, b}, 16'h1);
        slow = 1'b1;
        s0 = starts;
        trig_pulse();
        trig_pulse();
        sio_read(`AIO_SIO_IDX_BUSY, b);
        check("busy bit", {15'h0, b}, 16'h1);
        wait_on(0, 1'b0, 200);
        check("trig starts", 16'(starts), 16'(s0 + 1));
        check("trig chan", {10'h0, adc_chan}, chan_exp(last_ch));
        slow = 1'b0;
        sio_write(`AIO_SIO_IDX_TRIG_EN, 1'b0, sio_base);
        trig_pulse();
        tick(4);
        check("trig off", 16'(starts), 16'(s0 + 1));
        // bus i/o reset clears both modes
        sio_write(`AIO_SIO_IDX_TRIG_EN, 1'b1, sio_base);
        sio_write(`AIO_SIO_IDX_MEM_EN, 1'b1, sio_base);
        sio_read(`AIO_SIO_IDX_TRIG_EN, b);
        check("trig on", {15'h0, b}, 16'h1);
        io_rst_n = 1'b0;
        tick(4);
        io_rst_n = 1'b1;
        sio_read(`AIO_SIO_IDX_MEM_EN, b);
        check("io rst mem", {15'h0, b}, 16'h0);
        sio_read(`AIO_SIO_IDX_TRIG_EN, b);
        check("io rst trig", {15'h0, b}, 16'h0);
        // output latches in both address layouts; top four bits random
        for (k = 0; k < 8; k++) begin
            spread = k[2];
            dac_write(spread ? {dac_base[12:4], k[1:0], 5'h00} : {dac_base, k[1:0], 1'b0}, rnd);
            dac_exp[k[1:0]] = rnd[11:0];
            rnd = lfsr(rnd);
            check("dac", 16'(dac_val[k[1:0]]), 16'(dac_exp[k[1:0]]));
        end
        dac_write({dac_base, 2'h1, 1'b0}, rnd);
        for (i = 0; i < 4; i++)
            check("dac miss", 16'(dac_val[i]), 16'(dac_exp[i]));
        print_verdict();
    end
endmodule
